// File: common/pdp_pkg.sv
// shared constants and types for the synthesizer divider and detector core
`default_nettype none

package pdp_pkg;

    // register port
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 16;
    localparam logic [3:0]  CFG_ADDR    = 4'h0;
    localparam logic [3:0]  REFDIV_ADDR = 4'h4;
    localparam logic [3:0]  VCODIV_ADDR = 4'h8;
    localparam logic [3:0]  STATUS_ADDR = 4'hC;

    // counter and configuration word widths
    localparam int          REF_W       = 15;
    localparam int          VCO_W       = 16;
    localparam int          CFG_W       = 8;

    // configuration word, msb first: polarity, detector, lock, ref out, vco, ref
    typedef struct packed {
        logic       polaritySelect;
        logic       detectorSelect;
        logic       lockOutputEnable;
        logic [2:0] refOutSelect;
        logic       vcoPulseEnable;
        logic       refPulseEnable;
    } pdp_cfg_type;

    // ref out defaults to oscillator divided by 8, everything else cleared
    localparam logic [7:0]  CFG_RESET       = 8'h10;

    localparam logic [2:0]  REFSEL_LOW      = 3'h0;
    localparam logic [2:0]  REFSEL_DIRECT   = 3'h1;
    localparam logic [2:0]  REFSEL_DIV2     = 3'h2;
    localparam logic [2:0]  REFSEL_DIV4     = 3'h3;

    // prescaler and select field bit positions for the scaled reference
    localparam int          OSC_BIT_DIV2    = 0;
    localparam int          OSC_BIT_DIV4    = 1;
    localparam int          OSC_BIT_DIV8    = 2;
    localparam int          OSC_BIT_DIV16   = 3;
    localparam int          REFSEL_DIV16_BIT = 0;
    localparam int          REFSEL_HIGH_BIT = 2;

    // reference divide value that bypasses the counter
    localparam logic [14:0] REF_BYPASS      = 15'h0001;

    // reference pulse width in oscillator half periods (4.5 cycles)
    localparam logic [3:0]  REF_PULSE_HALVES = 4'h9;

    // phase detector states, one-hot
    typedef enum logic [3:0] {
        PD_IDLE    = 4'b0001,
        PD_REFLEAD = 4'b0010,
        PD_VCOLEAD = 4'b0100,
        PD_CLEAR   = 4'b1000
    } pdp_pd_type;

    // register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pdp_bus_type;

endpackage

`default_nettype wire

// File: design/pdp_counter.sv
// down counter with reload, used for the reference and feedback dividers
`default_nettype none

module pdp_counter
    import pdp_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // control
    input  wire logic         step,
    input  wire logic         load,
    input  wire logic [W-1:0] divisor,
    // terminal count pulse
    output logic              term
);

    typedef struct packed {
        logic [W-1:0] count;
        logic         term;
    } pdp_cnt_state_type;

    localparam logic [W-1:0] COUNT_LAST = W'(1);

    pdp_cnt_state_type s;
    pdp_cnt_state_type next_s;

    always_comb begin
        next_s      = s;
        next_s.term = 1'b0;
        if (load) begin
            next_s.count = divisor;
        end else if (step) begin
            if (s.count == COUNT_LAST) begin
                // reload on terminal count, one pulse per divide period
                next_s.count = divisor;
                next_s.term  = 1'b1;
            end else begin
                next_s.count = s.count - COUNT_LAST;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign term = s.term;

endmodule

`default_nettype wire

// File: design/pdp_core.sv
// reference and feedback dividers, phase/frequency detector and lock indicator
//
// The plain strobed port and the address map were left to the implementer.
`default_nettype none

module pdp_core
    import pdp_pkg::*;
#(
    parameter logic [14:0] REF_DIV_DEFAULT = 15'h0005,
    parameter logic [15:0] VCO_DIV_DEFAULT = 16'h0028
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // frequency inputs (asynchronous pins)
    input  wire logic        refOscInput,
    input  wire logic        vcoInput,
    // divider outputs
    output logic             scaledRefClockOut,
    output logic             refDividerPulse,
    output logic             vcoDividerPulse,
    // single-ended detector, three-state; enable low while driving
    output logic             singleEndedDetectorOut,
    output logic             singleEndedDetectorEnN,
    // double-ended detector, active low pulses
    output logic             vcoSideDetectorN,
    output logic             refSideDetectorN,
    // lock
    output logic             lockIndicator
);

    typedef struct packed {
        pdp_cfg_type  cfg;
        logic [14:0]  refDiv;
        logic [15:0]  vcoDiv;
        logic [1:0]   refSync;
        logic         refLast;
        logic [1:0]   vcoSync;
        logic         vcoLast;
        logic [3:0]   oscCount;
        logic [3:0]   refHalves;
        logic         vcoHigh;
        logic         jam;
        pdp_pd_type   pd;
        logic         scaled_ref_clock_out;
        logic         refPulse;
        logic         vcoPulse;
        logic         seOut;
        logic         seEnN;
        logic         vcoSideN;
        logic         refSideN;
        logic         lock;
        logic [15:0]  rdata;
    } pdp_state_type;

    localparam pdp_state_type RESET_STATE = '{
        cfg:      pdp_cfg_type'(CFG_RESET),
        refDiv:   REF_DIV_DEFAULT,
        vcoDiv:   VCO_DIV_DEFAULT,
        pd:       PD_IDLE,
        seEnN:    1'b1,
        vcoSideN: 1'b1,
        refSideN: 1'b1,
        default:  '0
    };

    pdp_state_type s;
    pdp_state_type next_s;
    pdp_bus_type   bus;

    logic refTerm;
    logic vcoTerm;
    logic refLevel;
    logic refRise;
    logic refFall;
    logic vcoRise;
    logic bypass;
    logic refEvent;
    logic pumpUp;
    logic pumpDown;

    assign bus      = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign refLevel = s.refSync[1];
    assign refRise  = refLevel & ~s.refLast;
    assign refFall  = ~refLevel & s.refLast;
    assign vcoRise  = s.vcoSync[1] & ~s.vcoLast;
    assign bypass   = (s.refDiv == REF_BYPASS);

    // a bypassed reference feeds the detector straight from the oscillator edge
    assign refEvent = bypass ? refRise : refTerm;

    pdp_counter #(.W(REF_W)) refCounter (
        .clk     (clk),
        .nrst    (nrst),
        .step    (refRise),
        .load    (s.jam),
        .divisor (s.refDiv),
        .term    (refTerm)
    );

    pdp_counter #(.W(VCO_W)) vcoCounter (
        .clk     (clk),
        .nrst    (nrst),
        .step    (vcoRise),
        .load    (s.jam),
        .divisor (s.vcoDiv),
        .term    (vcoTerm)
    );

    always_comb begin
        next_s     = s;
        next_s.jam = 1'b0;

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                CFG_ADDR:    next_s.cfg    = pdp_cfg_type'(bus.wdata[CFG_W-1:0]);
                REFDIV_ADDR: next_s.refDiv = bus.wdata[REF_W-1:0];
                VCODIV_ADDR: begin
                    next_s.vcoDiv = bus.wdata[VCO_W-1:0];
                    next_s.jam    = 1'b1;
                end
                default:     next_s.rdata = s.rdata;
            endcase
        end

        // read data stand for one cycle only
        next_s.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                CFG_ADDR:    next_s.rdata = DATA_W'(s.cfg);
                REFDIV_ADDR: next_s.rdata = DATA_W'(s.refDiv);
                VCODIV_ADDR: next_s.rdata = s.vcoDiv;
                STATUS_ADDR: next_s.rdata = DATA_W'({s.pd, s.lock, s.vcoPulse, s.refPulse});
                default:     next_s.rdata = '0;
            endcase
        end

        // two-stage synchronisers, third stage only for edge detection
        next_s.refSync = {s.refSync[0], refOscInput};
        next_s.refLast = s.refSync[1];
        next_s.vcoSync = {s.vcoSync[0], vcoInput};
        next_s.vcoLast = s.vcoSync[1];

        // prescaler for the scaled reference output
        if (refRise) begin
            next_s.oscCount = s.oscCount + 4'h1;
        end
        case (s.cfg.refOutSelect)
            REFSEL_LOW:    next_s.scaled_ref_clock_out = 1'b0;
            REFSEL_DIRECT: next_s.scaled_ref_clock_out = refLevel;
            REFSEL_DIV2:   next_s.scaled_ref_clock_out = s.oscCount[OSC_BIT_DIV2];
            REFSEL_DIV4:   next_s.scaled_ref_clock_out = s.oscCount[OSC_BIT_DIV4];
            default: begin
                next_s.scaled_ref_clock_out = s.cfg.refOutSelect[REFSEL_DIV16_BIT]
                              ? s.oscCount[OSC_BIT_DIV16] : s.oscCount[OSC_BIT_DIV8];
            end
        endcase

        // reference pulse: 9 oscillator half periods wide, or the oscillator level itself when bypassed
        if (s.jam) begin
            next_s.refHalves = '0;
        end else if (refTerm) begin
            next_s.refHalves = REF_PULSE_HALVES;
        end else if ((refRise | refFall) && s.refHalves != '0) begin
            next_s.refHalves = s.refHalves - 4'h1;
        end
        next_s.refPulse = s.cfg.refPulseEnable
                        & (bypass ? refLevel : (next_s.refHalves != '0));

        // vco pulse: high from terminal count to the next vco rising edge
        if (s.jam || vcoRise) begin
            next_s.vcoHigh = 1'b0;
        end
        if (vcoTerm) begin
            next_s.vcoHigh = 1'b1;
        end
        next_s.vcoPulse = s.cfg.vcoPulseEnable & next_s.vcoHigh;

        // phase/frequency detector; the clear state gives a one-cycle overlap
        // so that tiny phase errors still produce a pulse (no dead zone)
        case (s.pd)
            PD_IDLE, PD_CLEAR: begin
                if (refEvent && vcoTerm) begin
                    next_s.pd = PD_CLEAR;
                end else if (refEvent) begin
                    next_s.pd = PD_REFLEAD;
                end else if (vcoTerm) begin
                    next_s.pd = PD_VCOLEAD;
                end else begin
                    next_s.pd = PD_IDLE;
                end
            end
            PD_REFLEAD: next_s.pd = vcoTerm ? PD_CLEAR : PD_REFLEAD;
            PD_VCOLEAD: next_s.pd = refEvent ? PD_CLEAR : PD_VCOLEAD;
            default:    next_s.pd = PD_IDLE;
        endcase
        if (s.jam) begin
            next_s.pd = PD_IDLE;
        end

        pumpUp   = (next_s.pd == PD_REFLEAD) || (next_s.pd == PD_CLEAR);
        pumpDown = (next_s.pd == PD_VCOLEAD) || (next_s.pd == PD_CLEAR);

        // single-ended: drives only while exactly one side leads
        next_s.seEnN = ~(s.cfg.detectorSelect & (pumpUp ^ pumpDown));
        next_s.seOut = pumpDown ? s.cfg.polaritySelect
                                : ~s.cfg.polaritySelect;

        // double-ended: polarity swaps roles, single-ended mode parks both high
        if (s.cfg.detectorSelect) begin
            next_s.vcoSideN = 1'b1;
            next_s.refSideN = 1'b1;
        end else begin
            next_s.vcoSideN = ~(s.cfg.polaritySelect ? pumpUp : pumpDown);
            next_s.refSideN = ~(s.cfg.polaritySelect ? pumpDown : pumpUp);
        end

        next_s.lock = s.cfg.lockOutputEnable & ~(pumpUp | pumpDown);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign rdata                  = s.rdata;
    assign scaledRefClockOut      = s.scaled_ref_clock_out;
    assign refDividerPulse        = s.refPulse;
    assign vcoDividerPulse        = s.vcoPulse;
    assign singleEndedDetectorOut = s.seOut;
    assign singleEndedDetectorEnN = s.seEnN;
    assign vcoSideDetectorN       = s.vcoSideN;
    assign refSideDetectorN       = s.refSideN;
    assign lockIndicator          = s.lock;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence vcoDivWrite;
        bus.wr && bus.addr == VCODIV_ADDR;
    endsequence

    sequence detectorCleared;
        s.pd == PD_IDLE && singleEndedDetectorEnN && vcoSideDetectorN && refSideDetectorN;
    endsequence

    refOutStatic_a: assert property (
        s.cfg.refOutSelect == REFSEL_LOW |=> !scaledRefClockOut)
        else $error("scaled reference not static low");

    refPulseGate_a: assert property (
        !s.cfg.refPulseEnable |=> !refDividerPulse)
        else $error("reference pulse active while disabled");

    vcoPulseGate_a: assert property (
        !s.cfg.vcoPulseEnable |=> !vcoDividerPulse)
        else $error("vco pulse active while disabled");

    lockGate_a: assert property (
        !s.cfg.lockOutputEnable |=> !lockIndicator)
        else $error("lock output active while disabled");

    singleFloat_a: assert property (
        !s.cfg.detectorSelect |=> singleEndedDetectorEnN)
        else $error("single-ended output driven while disabled");

    dualParked_a: assert property (
        s.cfg.detectorSelect |=> vcoSideDetectorN && refSideDetectorN)
        else $error("dual outputs not parked high");

    jamClear_a: assert property (
        vcoDivWrite ##1 1'b1 |=> detectorCleared)
        else $error("detector not cleared after vco divide write");

    vcoLeadDrive_a: assert property (
        !singleEndedDetectorEnN && s.pd == PD_VCOLEAD
        |-> singleEndedDetectorOut == $past(s.cfg.polaritySelect))
        else $error("single-ended pulse direction wrong");

    lockHigh_a: assert property (
        s.cfg.lockOutputEnable && s.pd == PD_IDLE && !refEvent && !vcoTerm
        && !s.jam |=> lockIndicator)
        else $error("lock low without phase error");

    refPulseStart_a: assert property (
        !bypass && refTerm && !s.jam && !bus.wr && s.cfg.refPulseEnable
        && $stable(s.cfg) |=> refDividerPulse [*2])
        else $error("reference pulse not started");

endmodule

`default_nettype wire

// File: test/pdp_vco_model.sv
// stand-in for the external oscillator and vco driving the frequency pins
`default_nettype none

module pdp_vco_model #(
    parameter int OSC_HALF = 4,
    parameter int VCO_HALF = 4
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // frequency pins
    output logic      refOscInput,
    output logic      vcoInput
);
    timeunit 1ns;
    timeprecision 1ns;

    int tick;

    // one shared tick keeps equal-rate pins edge aligned, which the locked case needs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick <= 0;
        end else begin
            tick <= tick + 1;
        end
    end

    // 6.25 MHz oscillator stays under the scaled output limit for every select
    assign refOscInput = (tick % (2 * OSC_HALF)) >= OSC_HALF;
    // slow vco keeps the divided rate far below the detector limit
    assign vcoInput    = (tick % (2 * VCO_HALF)) >= VCO_HALF;

endmodule

`default_nettype wire

// File: test/pdp_core_bench.sv
// self-checking bench for the divider and detector core
`default_nettype none

module pdp_core_bench import pdp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [15:0] refDiv;
        logic [15:0] scaled;
        logic [1:0]  se;
        logic [2:0]  dual;
        logic [1:0]  lock;
    } pdp_row_type;

    // divides 50 (vco leads), 5 (vco lags), 40 (locked) against vco divide 40
    pdp_row_type rows [10] = '{
        '{8'h60, 16'h0032, 16'h0000, 2'b01, 3'b000, 2'b11},
        '{8'hE4, 16'h0032, 16'h0100, 2'b10, 3'b000, 2'b11},
        '{8'h68, 16'h0005, 16'h0080, 2'b10, 3'b000, 2'b11},
        '{8'hEC, 16'h0005, 16'h0040, 2'b01, 3'b000, 2'b11},
        '{8'h10, 16'h0032, 16'h0020, 2'b00, 3'b101, 2'b01},
        '{8'h94, 16'h0032, 16'h0010, 2'b00, 3'b011, 2'b01},
        '{8'h38, 16'h0005, 16'h0020, 2'b00, 3'b011, 2'b11},
        '{8'hBC, 16'h0005, 16'h0010, 2'b00, 3'b101, 2'b11},
        '{8'h20, 16'h0028, 16'h0000, 2'b00, 3'b001, 2'b11},
        '{8'h60, 16'h0028, 16'h0000, 2'b00, 3'b000, 2'b11}
    };

    logic        clk;
    logic        nrst;
    pdp_bus_type bus;
    logic [15:0] rdata;
    logic        refOscInput;
    logic        vcoInput;
    logic        scaledRefClockOut;
    logic        refDividerPulse;
    logic        vcoDividerPulse;
    logic        singleEndedDetectorOut;
    logic        singleEndedDetectorEnN;
    logic        vcoSideDetectorN;
    logic        refSideDetectorN;
    logic        lockIndicator;
    logic        meas;
    logic        lastSc;
    logic        lastRp;
    logic        lastVp;
    logic [15:0] v;
    int          errors;
    int          samples_checked;
    int          scRise, rpRise, vpRise, seLo, seHi, vOnly, rOnly, both, lkHi, lkLo;
    int          n;
    time         t0;

    pdp_core dut (
        .clk                    (clk),
        .nrst                   (nrst),
        .addr                   (bus.addr),
        .wdata                  (bus.wdata),
        .wr                     (bus.wr),
        .rd                     (bus.rd),
        .rdata                  (rdata),
        .refOscInput            (refOscInput),
        .vcoInput               (vcoInput),
        .scaledRefClockOut      (scaledRefClockOut),
        .refDividerPulse        (refDividerPulse),
        .vcoDividerPulse        (vcoDividerPulse),
        .singleEndedDetectorOut (singleEndedDetectorOut),
        .singleEndedDetectorEnN (singleEndedDetectorEnN),
        .vcoSideDetectorN       (vcoSideDetectorN),
        .refSideDetectorN       (refSideDetectorN),
        .lockIndicator          (lockIndicator)
    );

    pdp_vco_model #(.OSC_HALF(4), .VCO_HALF(4)) vco (
        .clk         (clk),
        .nrst        (nrst),
        .refOscInput (refOscInput),
        .vcoInput    (vcoInput)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic near(input int a, input int b, input int t);
        return a >= b - t && a <= b + t;
    endfunction

    task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rdReg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // read data stands for one cycle only, so the following cycle must show zero
    task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rdReg(a, d);
        check(d, exp);
        @(posedge clk);
        #1 check(rdata, 16'h0000);
    endtask

    task automatic measure(input int cycles);
        {scRise, rpRise, vpRise, seLo, seHi, vOnly, rOnly, both, lkHi, lkLo} = '0;
        meas = 1'b1;
        repeat (cycles) @(posedge clk);
        meas = 1'b0;
    endtask

    // sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        if (meas) begin
            scRise += int'(scaledRefClockOut && !lastSc);
            rpRise += int'(refDividerPulse && !lastRp);
            vpRise += int'(vcoDividerPulse && !lastVp);
            seLo += int'(!singleEndedDetectorEnN && !singleEndedDetectorOut);
            seHi += int'(!singleEndedDetectorEnN && singleEndedDetectorOut);
            vOnly += int'(!vcoSideDetectorN && refSideDetectorN);
            rOnly += int'(vcoSideDetectorN && !refSideDetectorN);
            both += int'(!vcoSideDetectorN && !refSideDetectorN);
            lkHi += int'(lockIndicator);
            lkLo += int'(!lockIndicator);
        end
        {lastSc, lastRp, lastVp} = {scaledRefClockOut, refDividerPulse, vcoDividerPulse};
    end

    task automatic print_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // whole run is about 25000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        print_verdict();
    end

    initial begin
        nrst = 1'b0;
        bus = '0;
        meas = 1'b0;
        repeat (12) @(posedge clk);
        check(singleEndedDetectorEnN, 1'b1);
        check({refDividerPulse, vcoDividerPulse, lockIndicator}, 3'b000);
        nrst <= 1'b1;
        rdChk(CFG_ADDR, 16'h0010);
        measure(512);
        check(near(scRise, 8, 1), 1'b1);
        check(rpRise + vpRise + lkHi, 0);
        wrReg(REFDIV_ADDR, 16'hFFFF);
        rdChk(REFDIV_ADDR, 16'h7FFF);
        rdChk(4'h2, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            wrReg(CFG_ADDR, {8'h00, rows[i].cfg});
            wrReg(REFDIV_ADDR, rows[i].refDiv);
            wrReg(VCODIV_ADDR, 16'h0028);
            // outputs show the old detector state until the jam has taken hold
            repeat (2) @(posedge clk);
            measure(2048);
            check(near(scRise, int'(rows[i].scaled), 1), 1'b1);
            check({seHi > 0, seLo > 0}, rows[i].se);
            check({vOnly > 0, rOnly > 0, both > 0}, rows[i].dual);
            check({lkHi > 0, lkLo > 0}, rows[i].lock);
            if (rows[i].refDiv == 16'h0028 && rows[i].cfg[5]) begin
                check(lkLo * 8 < lkHi, 1'b1);
            end
        end
        // a lagging vco keeps the detector busy until the jam load
        wrReg(REFDIV_ADDR, 16'h0005);
        repeat (400) @(posedge clk);
        wrReg(VCODIV_ADDR, 16'h0028);
        repeat (2) @(posedge clk);
        rdReg(STATUS_ADDR, v);
        check(v[6:3], 4'b0001);
        wrReg(CFG_ADDR, 16'h0013);
        @(posedge refDividerPulse);
        t0 = $time;
        @(posedge refDividerPulse);
        check(32'(($time - t0) / 20), 40);
        n = 0;
        while (refDividerPulse === 1'b1) begin
            @(negedge clk);
            n++;
        end
        check(near(n - 1, 36, 1), 1'b1);
        @(posedge vcoDividerPulse);
        t0 = $time;
        @(posedge vcoDividerPulse);
        check(32'(($time - t0) / 20), 320);
        // bypass is checked at the pulse output only here, the detector result is not judged
        wrReg(REFDIV_ADDR, 16'h0001);
        measure(512);
        check(near(rpRise, 64, 1), 1'b1);
        wrReg(CFG_ADDR, 16'h0010);
        @(posedge clk);
        measure(512);
        check(rpRise + vpRise + lkHi, 0);
        print_verdict();
    end

endmodule

`default_nettype wire
